// >>> verilog/doc_cfg.svh
`ifndef DOC_CFG_SVH
`define DOC_CFG_SVH
// Timing
`define DOC_CLK_HZ          200000000
`define DOC_TICK_MS_HZ      1000
`define DOC_TICK_CYCLES     (`DOC_CLK_HZ / `DOC_TICK_MS_HZ)
`define DOC_DELAY_MAX_MS    16'd60000
`define DOC_HOLD_MAX_MS     16'd9999
// Reset values
`define DOC_DELAY_RST       16'h0000
`define DOC_HOLD_RST        16'h0000
`define DOC_LEVEL_RST       1'b1
`define DOC_FALLBACK_RST    1'b0
`define DOC_OUT_RST         1'b0
// Assignment codes
`define DOC_ASG_NONE        4'h0
`define DOC_ASG_FAULT       4'h1
`define DOC_ASG_MAINS       4'h2
`define DOC_ASG_DCCHG       4'h3
`define DOC_ASG_BRAKE       4'h4
`define DOC_ASG_OUTCON      4'h5
`define DOC_ASG_GENERIC     4'h6
`define DOC_ASG_COMM        4'h7
`endif

// >>> verilog/doc_pkg.sv
package doc_pkg;
  typedef struct packed {
    logic [15:0] delay_ms;
    logic [15:0] hold_ms;
    logic        level_pos;
    logic        fallback;
  } doc_cfg_type;

  typedef enum logic [1:0] {
    DOC_IDLE  = 2'b00,
    DOC_DELAY = 2'b01,
    DOC_HOLD  = 2'b10
  } doc_state_type;
endpackage

// >>> verilog/doc_output.sv
`timescale 1ns/10ps
`default_nettype none
`include "doc_cfg.svh"
// Overview of operation
// - Event rising waits activation delay, 1 ms steps, up to 60000 ms.
// - Event falling waits holding delay, 1 ms steps, up to 9999 ms.
// - Five protected assignments force both delays to zero, ignoring writes.
// - Active level selects output value for a true event; default one.
// - Protected assignments force positive polarity.
// - Enabled comm-controlled output is not disabled by fault state.
// - Fallback off: unassigned command-driven output holds value on error.
// - Fallback off: fieldbus output stays active through fault state.
// - Fallback on: output follows command bit, disabled on error.
// - Delays and active level keep applying during errors.
// - Small units: shared input function assigned stops output use.
// - Large units: pulse train function assigned with output select switch set stops output use.
// - Fallback forced off when shared input, pulse train or output assigned.
// - Large units with pulse train and output select switch: error selects minimum pulse frequency.
module doc_output #(
  parameter int TICK_CYCLES = `DOC_TICK_CYCLES,
  parameter bit LARGE_UNIT  = 1'b0
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_clk_en,
  // Configuration
  input  wire logic [3:0]        i_assignment,
  input  wire doc_pkg::doc_cfg_type i_cfg,
  input  wire logic              i_cfg_write,
  input  wire logic              i_shared_input_assigned,
  input  wire logic              i_pulse_train_assigned,
  input  wire logic              i_output_select_switch,
  // Sources
  input  wire logic              i_event,
  input  wire logic              i_comm_command_bit,
  input  wire logic              i_error,
  // Outputs
  output logic                   o_digital_output_n,
  output logic                   o_pin_is_output,
  output logic                   o_pulse_min_freq,
  output doc_pkg::doc_cfg_type   o_cfg_eff
);
  default clocking dc_sys @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  function automatic logic is_protected(input logic [3:0] asg);
    is_protected = (asg == `DOC_ASG_FAULT) || (asg == `DOC_ASG_MAINS) ||
                   (asg == `DOC_ASG_DCCHG) || (asg == `DOC_ASG_BRAKE) ||
                   (asg == `DOC_ASG_OUTCON);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Configuration store
  doc_pkg::doc_cfg_type cfg;
  doc_pkg::doc_cfg_type next_cfg;
  logic                 prot;
  logic                 pin_taken;
  logic                 any_assigned;
  always_comb begin
    prot = is_protected(i_assignment);
    pin_taken = (!LARGE_UNIT && i_shared_input_assigned) ||
                (LARGE_UNIT && i_pulse_train_assigned &&
                 i_output_select_switch);
    any_assigned = i_shared_input_assigned || i_pulse_train_assigned ||
                   (i_assignment != `DOC_ASG_NONE);
    next_cfg = cfg;
    if (i_cfg_write) begin
      next_cfg = i_cfg;
      if (next_cfg.delay_ms > `DOC_DELAY_MAX_MS) begin
        next_cfg.delay_ms = `DOC_DELAY_MAX_MS;
      end
      if (next_cfg.hold_ms > `DOC_HOLD_MAX_MS) begin
        next_cfg.hold_ms = `DOC_HOLD_MAX_MS;
      end
    end
    if (prot) begin
      next_cfg.delay_ms = `DOC_DELAY_RST;
      next_cfg.hold_ms  = `DOC_HOLD_RST;
      next_cfg.level_pos = 1'b1;
    end
    if (any_assigned) begin
      next_cfg.fallback = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg <= '{`DOC_DELAY_RST, `DOC_HOLD_RST, `DOC_LEVEL_RST,
               `DOC_FALLBACK_RST};
    end else if (i_clk_en) begin
      cfg <= next_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        tick;
  always_comb begin
    tick = (tick_cnt == 32'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt <= 32'h0;
    end else if (i_clk_en) begin
      tick_cnt <= next_tick_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Source selection
  logic src;
  logic held;
  logic next_held;
  always_comb begin
    next_held = held;
    if (i_assignment == `DOC_ASG_NONE || i_assignment == `DOC_ASG_COMM) begin
      if (cfg.fallback && i_error) begin
        next_held = 1'b0;
      end else if (!i_error) begin
        next_held = i_comm_command_bit;
      end
      src = next_held;
    end else begin
      src = i_event;
      next_held = i_event;
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      held <= 1'b0;
    end else if (i_clk_en) begin
      held <= next_held;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Delay machine; error does not bypass it
  doc_pkg::doc_state_type state;
  doc_pkg::doc_state_type next_state;
  logic [15:0]            ms_cnt;
  logic [15:0]            next_ms_cnt;
  logic                   evt_state;
  logic                   next_evt_state;
  always_comb begin
    next_state = state;
    next_ms_cnt = ms_cnt;
    next_evt_state = evt_state;
    unique case (state)
      doc_pkg::DOC_IDLE: begin
        next_ms_cnt = 16'h0;
        if (src && !evt_state) begin
          if (cfg.delay_ms == 16'h0) begin
            next_evt_state = 1'b1;
          end else begin
            next_state = doc_pkg::DOC_DELAY;
          end
        end else if (!src && evt_state) begin
          if (cfg.hold_ms == 16'h0) begin
            next_evt_state = 1'b0;
          end else begin
            next_state = doc_pkg::DOC_HOLD;
          end
        end
      end
      doc_pkg::DOC_DELAY: begin
        if (!src) begin
          next_state = doc_pkg::DOC_IDLE;
        end else if (tick) begin
          if (ms_cnt + 16'h1 >= cfg.delay_ms) begin
            next_evt_state = 1'b1;
            next_state = doc_pkg::DOC_IDLE;
          end else begin
            next_ms_cnt = ms_cnt + 16'h1;
          end
        end
      end
      doc_pkg::DOC_HOLD: begin
        if (src) begin
          next_state = doc_pkg::DOC_IDLE;
        end else if (tick) begin
          if (ms_cnt + 16'h1 >= cfg.hold_ms) begin
            next_evt_state = 1'b0;
            next_state = doc_pkg::DOC_IDLE;
          end else begin
            next_ms_cnt = ms_cnt + 16'h1;
          end
        end
      end
      default: begin
        next_state = doc_pkg::DOC_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= doc_pkg::DOC_IDLE;
      ms_cnt <= 16'h0;
      evt_state <= 1'b0;
    end else if (i_clk_en) begin
      state <= next_state;
      ms_cnt <= next_ms_cnt;
      evt_state <= next_evt_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output stage
  logic next_out;
  logic next_min_freq;
  always_comb begin
    next_out = pin_taken ? `DOC_OUT_RST : (evt_state == cfg.level_pos);
    next_min_freq = LARGE_UNIT && i_output_select_switch &&
                    i_pulse_train_assigned && i_error;
  end
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_digital_output_n <= `DOC_OUT_RST;
      o_pulse_min_freq   <= 1'b0;
      o_pin_is_output    <= 1'b1;
    end else if (i_clk_en) begin
      o_digital_output_n <= next_out;
      o_pulse_min_freq   <= next_min_freq;
      o_pin_is_output    <= !pin_taken;
    end
  end
  assign o_cfg_eff = cfg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_prot_zero;
    (i_clk_en && prot) |=> (cfg.delay_ms == 16'h0 && cfg.hold_ms == 16'h0);
  endproperty
  a_prot_zero: assert property (p_prot_zero) else $error("delays kept");
  property p_prot_pos;
    (i_clk_en && prot) |=> cfg.level_pos;
  endproperty
  a_prot_pos: assert property (p_prot_pos) else $error("level not pos");
  property p_fb_off;
    (i_clk_en && any_assigned) |=> !cfg.fallback;
  endproperty
  a_fb_off: assert property (p_fb_off) else $error("fallback kept");
  property p_delay_max;
    cfg.delay_ms <= `DOC_DELAY_MAX_MS && cfg.hold_ms <= `DOC_HOLD_MAX_MS;
  endproperty
  a_delay_max: assert property (p_delay_max) else $error("range");
  property p_fb_err;
    (i_clk_en && cfg.fallback && i_error &&
     i_assignment == `DOC_ASG_NONE) |=> !held;
  endproperty
  a_fb_err: assert property (p_fb_err) else $error("no fallback");
  property p_hold_err;
    (i_clk_en && !cfg.fallback && i_error &&
     i_assignment == `DOC_ASG_NONE) |=> $stable(held);
  endproperty
  a_hold_err: assert property (p_hold_err) else $error("not held");
  property p_level;
    (i_clk_en && !pin_taken) |=>
      o_digital_output_n == ($past(evt_state) == $past(cfg.level_pos));
  endproperty
  a_level: assert property (p_level) else $error("level wrong");
  property p_taken;
    (i_clk_en && pin_taken) |=> !o_pin_is_output;
  endproperty
  a_taken: assert property (p_taken) else $error("pin kept");
  property p_restart;
    (i_clk_en && state == doc_pkg::DOC_DELAY && !src) |=>
      state == doc_pkg::DOC_IDLE && !evt_state;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  c_delay: cover property (@(posedge i_clk_sys) state == doc_pkg::DOC_DELAY);
  c_hold: cover property (@(posedge i_clk_sys) state == doc_pkg::DOC_HOLD);
  c_err: cover property (@(posedge i_clk_sys) i_error && cfg.fallback);

endmodule
`default_nettype wire

// >>> tb/doc_load_model.sv
`timescale 1ns/10ps
`default_nettype none
// Terminal load: counts energizing edges so short glitches stay visible
module doc_load_model (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // Terminal
  input  wire logic       i_terminal,
  input  wire logic       i_pin_is_output,
  // Observation
  output logic            o_energized,
  output logic [7:0]      o_edge_count
);
  logic prev;
  // A pin taken by another function leaves the load unpowered
  assign o_energized = i_terminal & i_pin_is_output;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev         <= 1'b0;
      o_edge_count <= 8'h00;
    end else begin
      prev <= o_energized;
      if (o_energized && !prev) begin
        o_edge_count <= o_edge_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/doc_output_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module doc_output_tb_top;
  localparam int TICK = 4;
  typedef struct packed {
    logic [3:0] asg;
    logic [3:0] dly;
    logic       lvl, fb, evt, cmd, err, exp_out, exp_fb;
  } doc_row_type;
  logic                 clk_sys, reset_n, clk_en, cfg_wr, sh_asg, pt_asg;
  logic                 sel_sw, evt, cmd, err, dout, pin_out, minf;
  logic                 dout_l, pin_l, minf_l, energized;
  logic [3:0]           asg;
  logic [7:0]           edges, e0;
  doc_pkg::doc_cfg_type cfg, cfg_eff, cfg_l;
  int                   errors, cmp_count;
  doc_row_type rows [0:12] = '{
    '{4'h6, 4'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h6, 4'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0},
    '{4'h6, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h1, 4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h2, 4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h3, 4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h4, 4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h5, 4'h3, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{4'h0, 4'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
    '{4'h0, 4'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h1},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0},
    '{4'h0, 4'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0},
    '{4'h7, 4'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0}};
  ////////////////////////////////////////////////////////////////////////
  // Both sizes share stimulus so pin sharing can be compared side by side
  doc_output #(.TICK_CYCLES(TICK), .LARGE_UNIT(1'b0)) dut (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(clk_en),
    .i_assignment(asg), .i_cfg(cfg), .i_cfg_write(cfg_wr),
    .i_shared_input_assigned(sh_asg), .i_pulse_train_assigned(pt_asg),
    .i_output_select_switch(sel_sw), .i_event(evt),
    .i_comm_command_bit(cmd), .i_error(err), .o_digital_output_n(dout),
    .o_pin_is_output(pin_out), .o_pulse_min_freq(minf), .o_cfg_eff(cfg_eff));
  doc_output #(.TICK_CYCLES(TICK), .LARGE_UNIT(1'b1)) dut_large (
    .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(clk_en),
    .i_assignment(asg), .i_cfg(cfg), .i_cfg_write(cfg_wr),
    .i_shared_input_assigned(sh_asg), .i_pulse_train_assigned(pt_asg),
    .i_output_select_switch(sel_sw), .i_event(evt),
    .i_comm_command_bit(cmd), .i_error(err), .o_digital_output_n(dout_l),
    .o_pin_is_output(pin_l), .o_pulse_min_freq(minf_l), .o_cfg_eff(cfg_l));
  doc_load_model load (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
    .i_terminal(dout), .i_pin_is_output(pin_out),
    .o_energized(energized), .o_edge_count(edges));
  ////////////////////////////////////////////////////////////////////////
  task automatic check_bit(input string nm, input logic e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic check_cnt(input string nm, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_cfg(input doc_pkg::doc_cfg_type e, g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error cfg_eff expected %h seen %h", e, g);
    end
  endtask
  task automatic finish_test();
    $display("Counts: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wait_out(input logic e, input int n);
    int k;
    k = 0;
    while (dout !== e && k < n) begin
      @(negedge clk_sys);
      k++;
    end
    check_bit("out_wait", e, dout);
    if (dout !== e) begin
      finish_test();
    end
  endtask
  task automatic write_cfg(input logic [15:0] d, h, input logic l, f);
    @(negedge clk_sys);
    cfg = '{d, h, l, f};
    cfg_wr = 1'b1;
    @(negedge clk_sys);
    cfg_wr = 1'b0;
  endtask
  function automatic doc_pkg::doc_cfg_type exp_cfg(input doc_row_type r);
    logic [15:0] d;
    logic        p;
    // Protected codes ignore written delays and polarity
    p = (r.asg >= 4'h1) && (r.asg <= 4'h5);
    d = p ? 16'h0000 : {12'h000, r.dly};
    exp_cfg = '{d, d, p | r.lvl, r.exp_fb};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {reset_n, cfg_wr, sh_asg, pt_asg, sel_sw, evt, cmd, err} = 8'h00;
    clk_en = 1'b1;
    asg = 4'h0;
    cfg = '0;
    errors = 0;
    cmp_count = 0;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    check_bit("out", 1'b0, dout);
    check_cfg('{16'h0000, 16'h0000, 1'b1, 1'b0}, cfg_eff);
    $display("Test reset done");
    foreach (rows[i]) begin
      @(negedge clk_sys);
      {asg, evt, cmd, err} = {rows[i].asg, rows[i].evt, rows[i].cmd,
                              rows[i].err};
      write_cfg({12'h000, rows[i].dly}, {12'h000, rows[i].dly},
                rows[i].lvl, rows[i].fb);
      repeat (6) @(negedge clk_sys);
      check_bit("out", rows[i].exp_out, dout);
      check_cfg(exp_cfg(rows[i]), cfg_eff);
      $display("Test row %0d done", i);
    end
    // Error stays present: it must not bypass the timers
    asg = 4'h6;
    evt = 1'b0;
    write_cfg(16'h0003, 16'h0002, 1'b1, 1'b0);
    repeat (6) @(negedge clk_sys);
    evt = 1'b1;
    repeat (3 * TICK - 2) @(negedge clk_sys);
    check_bit("out_early", 1'b0, dout);
    wait_out(1'b1, 2 * TICK + 2);
    // The load counts a rising edge one clock after the output rises
    @(negedge clk_sys);
    e0 = edges;
    evt = 1'b0;
    repeat (TICK) @(negedge clk_sys);
    evt = 1'b1;
    repeat (5 * TICK) @(negedge clk_sys);
    check_cnt("edges", e0, edges);
    evt = 1'b0;
    repeat (2 * TICK - 2) @(negedge clk_sys);
    check_bit("out_hold", 1'b1, dout);
    wait_out(1'b0, 2 * TICK + 2);
    evt = 1'b1;
    repeat (TICK) @(negedge clk_sys);
    evt = 1'b0;
    repeat (6 * TICK) @(negedge clk_sys);
    check_cnt("edges_short", e0, edges);
    $display("Test timers done");
    asg = 4'h0;
    err = 1'b0;
    cmd = 1'b1;
    sh_asg = 1'b1;
    write_cfg(16'h0000, 16'h0000, 1'b1, 1'b1);
    repeat (6) @(negedge clk_sys);
    check_bit("pin", 1'b0, pin_out);
    check_bit("load", 1'b0, energized);
    check_bit("fb", 1'b0, cfg_eff.fallback);
    sh_asg = 1'b0;
    pt_asg = 1'b1;
    sel_sw = 1'b1;
    err = 1'b1;
    repeat (6) @(negedge clk_sys);
    check_bit("pin_large", 1'b0, pin_l);
    check_bit("minf_large", 1'b1, minf_l);
    check_bit("minf", 1'b0, minf);
    check_bit("fb_large", 1'b0, cfg_l.fallback);
    check_bit("out_large", 1'b0, dout_l);
    $display("Test pin sharing done");
    // Clock enable low must freeze the pin state
    pt_asg = 1'b0;
    clk_en = 1'b0;
    repeat (6) @(negedge clk_sys);
    check_bit("pin_frozen", 1'b0, pin_l);
    clk_en = 1'b1;
    repeat (6) @(negedge clk_sys);
    check_bit("pin_back", 1'b1, pin_l);
    $display("Test clock enable done");
    // Mid-run reset drops the output and restores defaults
    write_cfg(16'h0005, 16'h0004, 1'b1, 1'b0);
    repeat (6) @(negedge clk_sys);
    check_bit("out_pre", 1'b1, dout);
    reset_n = 1'b0;
    @(negedge clk_sys);
    check_bit("out_rst", 1'b0, dout);
    reset_n = 1'b1;
    @(negedge clk_sys);
    check_cfg('{16'h0000, 16'h0000, 1'b1, 1'b0}, cfg_eff);
    check_bit("out_post", 1'b0, dout);
    $display("Test reset mid-run done");
    finish_test();
  end
endmodule
`default_nettype wire
